// ==== hstc_pkg.sv ====
// shared constants, types and register map of the compare-output control
package hstc_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 10;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL_A   = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_WAVE_CFG = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h2;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CA_MODE_HI = 7;
   localparam int CA_MODE_LO = 6;
   localparam int CB_MODE_HI = 5;
   localparam int CB_MODE_LO = 4;
   localparam int CA_FORCE   = 3;
   localparam int CA_PWM     = 1;
   localparam int CB_PWM     = 0;
   localparam int WG_LO      = 0;
   localparam int WG_HI      = 1;
   localparam int ST_WAVE_A  = 0;
   localparam int ST_WAVE_B  = 1;
   localparam int ST_OVR_LO  = 4;
   localparam int ST_OVR_HI  = 7;

   // ---------------------------------------------------------------
   // reset values and masks
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] CTRL_A_RST   = 8'h00;
   localparam logic [DATA_W-1:0] CTRL_A_STORE = 8'hF3;
   localparam logic [DATA_W-1:0] WAVE_CFG_RST = 8'h00;
   localparam logic [DATA_W-1:0] WAVE_CFG_MSK = 8'h03;
   localparam logic [DATA_W-1:0] RD_NONE      = 8'h00;
   localparam logic [CNT_W-1:0]  CNT_BOTTOM   = 10'h000;

   // ---------------------------------------------------------------
   // output-mode field codes and waveform modes
   // ---------------------------------------------------------------
   localparam logic [1:0] OM_PORT   = 2'h0;
   localparam logic [1:0] OM_TOGGLE = 2'h1;
   localparam logic [1:0] OM_CLEAR  = 2'h2;
   localparam logic [1:0] OM_SET    = 2'h3;

   typedef enum logic [4:0] {
      WM_NORMAL = 5'h01,
      WM_FAST   = 5'h02,
      WM_PFC    = 5'h04,
      WM_SIX_SS = 5'h08,
      WM_SIX_DS = 5'h10
   } hstc_wmode_t;

   typedef struct packed {
      logic a;
      logic a_n;
      logic b;
      logic b_n;
   } hstc_pins_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } hstc_bus_req_t;

endpackage : hstc_pkg

// ==== hstc_cmp_out.sv ====
// compare-output control for channels a and b of the high-speed timer
//
// Design decisions made here: the register offsets and the address-and-strobe port.
module hstc_cmp_out (
   input  wire logic                        clk_in,
   input  wire logic                        arst_n_in,
   input  wire hstc_pkg::hstc_bus_req_t     bus_req_in,
   output logic [hstc_pkg::DATA_W-1:0]      bus_rdata_out,
   input  wire logic [hstc_pkg::CNT_W-1:0]  hs_counter_value_in,
   input  wire logic                        count_down_in,
   input  wire logic                        timer_tick_in,
   input  wire logic [hstc_pkg::CNT_W-1:0]  chan_a_compare_value_in,
   input  wire logic [hstc_pkg::CNT_W-1:0]  chan_b_compare_value_in,
   input  wire hstc_pkg::hstc_pins_t        port_dir_in,
   output hstc_pkg::hstc_pins_t             pin_val_out,
   output hstc_pkg::hstc_pins_t             pin_ovr_out,
   output hstc_pkg::hstc_pins_t             pin_oe_out,
   output logic                             chan_a_waveform_out,
   output logic                             chan_b_waveform_out,
   output logic                             chan_a_match_out,
   output logic                             chan_b_match_out
);
   import hstc_pkg::*;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------

   // comparator shared by both channels
   function automatic logic cmp_eq(
      input logic [CNT_W-1:0] cnt,
      input logic [CNT_W-1:0] cmp
   );
      cmp_eq = (cnt == cmp);
   endfunction : cmp_eq

   // channel b never sees the high mode bit, so six-output is a only
   function automatic hstc_wmode_t mode_of(
      input logic pwm_en,
      input logic wg_lo,
      input logic wg_hi
   );
      hstc_wmode_t m;
      m = WM_NORMAL;
      if (pwm_en) begin
         unique case ({wg_hi, wg_lo})
            2'b00: m = WM_FAST;
            2'b01: m = WM_PFC;
            2'b10: m = WM_SIX_SS;
            2'b11: m = WM_SIX_DS;
         endcase
      end
      mode_of = m;
   endfunction : mode_of

   // next waveform level from mode, field and timer events
   function automatic logic wave_next(
      input hstc_wmode_t m,
      input logic [1:0]  f,
      input logic        cur,
      input logic        match,
      input logic        zero,
      input logic        down
   );
      logic r;
      r = cur;
      // field 00 leaves the level alone
      if (f != OM_PORT) begin
         unique case (m)
            WM_NORMAL: begin
               if (match) begin
                  r = (f == OM_TOGGLE) ? ~cur : (f == OM_SET);
               end
            end
            WM_FAST, WM_SIX_SS: begin
               // match taken after zero so a compare of 0 wins
               if (zero) begin
                  r = (f != OM_SET);
               end
               if (match) begin
                  r = (f == OM_SET);
               end
            end
            WM_PFC, WM_SIX_DS: begin
               if (match) begin
                  r = (f == OM_SET) ^ down;
               end
            end
         endcase
      end
      wave_next = r;
   endfunction : wave_next

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] ctrl_a_r;
   logic [DATA_W-1:0] ctrl_a_nxt;
   logic [DATA_W-1:0] wave_cfg_r;
   logic [DATA_W-1:0] wave_cfg_nxt;
   logic              wave_a_r;
   logic              wave_a_nxt;
   logic              wave_b_r;
   logic              wave_b_nxt;
   logic [DATA_W-1:0] rdata_nxt;
   hstc_pins_t        pin_val_nxt;
   hstc_pins_t        pin_ovr_nxt;
   hstc_pins_t        pin_oe_nxt;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire logic wr_ctrl;
   wire logic wr_cfg;
   wire logic rd_ctrl;
   wire logic rd_cfg;
   wire logic rd_stat;

   assign wr_ctrl = bus_req_in.wr && (bus_req_in.addr == OFS_CTRL_A);
   assign wr_cfg  = bus_req_in.wr && (bus_req_in.addr == OFS_WAVE_CFG);
   assign rd_ctrl = bus_req_in.rd && (bus_req_in.addr == OFS_CTRL_A);
   assign rd_cfg  = bus_req_in.rd && (bus_req_in.addr == OFS_WAVE_CFG);
   assign rd_stat = bus_req_in.rd && (bus_req_in.addr == OFS_STATUS);

   // force is a strobe, never stored
   assign ctrl_a_nxt = wr_ctrl ? (bus_req_in.wdata & CTRL_A_STORE)
                               : ctrl_a_r;
   assign wave_cfg_nxt = wr_cfg ? (bus_req_in.wdata & WAVE_CFG_MSK)
                                : wave_cfg_r;

   // ---------------------------------------------------------------
   // mode decode, from the values that take effect this edge
   // ---------------------------------------------------------------
   wire logic [1:0]  field_a;
   wire logic [1:0]  field_b;
   hstc_wmode_t      mode_a;
   hstc_wmode_t      mode_b;
   wire logic        six_a;

   assign field_a = {ctrl_a_nxt[CA_MODE_HI], ctrl_a_nxt[CA_MODE_LO]};
   assign field_b = {ctrl_a_nxt[CB_MODE_HI], ctrl_a_nxt[CB_MODE_LO]};
   assign mode_a  = mode_of(ctrl_a_nxt[CA_PWM], wave_cfg_nxt[WG_LO],
                            wave_cfg_nxt[WG_HI]);
   assign mode_b  = mode_of(ctrl_a_nxt[CB_PWM], wave_cfg_nxt[WG_LO],
                            1'b0);
   assign six_a   = (mode_a == WM_SIX_SS) || (mode_a == WM_SIX_DS);

   // ---------------------------------------------------------------
   // timer events
   // ---------------------------------------------------------------
   wire logic match_a;
   wire logic match_b;
   wire logic at_zero;
   wire logic force_a;

   assign match_a = timer_tick_in &&
                    cmp_eq(hs_counter_value_in, chan_a_compare_value_in);
   assign match_b = timer_tick_in &&
                    cmp_eq(hs_counter_value_in, chan_b_compare_value_in);
   assign at_zero = timer_tick_in &&
                    cmp_eq(hs_counter_value_in, CNT_BOTTOM);
   assign force_a = wr_ctrl && bus_req_in.wdata[CA_FORCE] &&
                    !ctrl_a_nxt[CA_PWM];

   // ---------------------------------------------------------------
   // waveform generation
   // ---------------------------------------------------------------
   assign wave_a_nxt = wave_next(mode_a, field_a, wave_a_r,
                                 match_a || force_a, at_zero,
                                 count_down_in);
   assign wave_b_nxt = wave_next(mode_b, field_b, wave_b_r,
                                 match_b, at_zero, count_down_in);

   // ---------------------------------------------------------------
   // pin connection
   // ---------------------------------------------------------------
   wire logic a_true;
   wire logic a_comp;
   wire logic b_true;
   wire logic b_comp;

   assign a_true = (field_a != OM_PORT);
   // complement never joins in non-pwm operation
   assign a_comp = six_a ? a_true
                 : (mode_a != WM_NORMAL) && (field_a == OM_TOGGLE);
   // in six-output mode every pair follows channel a
   assign b_true = six_a ? a_true : (field_b != OM_PORT);
   assign b_comp = six_a ? a_true
                 : (mode_b != WM_NORMAL) && (field_b == OM_TOGGLE);

   assign pin_val_nxt.a   = wave_a_nxt;
   assign pin_val_nxt.a_n = ~wave_a_nxt;
   assign pin_val_nxt.b   = six_a ? wave_a_nxt : wave_b_nxt;
   assign pin_val_nxt.b_n = six_a ? ~wave_a_nxt : ~wave_b_nxt;

   assign pin_ovr_nxt.a   = a_true;
   assign pin_ovr_nxt.a_n = a_comp;
   assign pin_ovr_nxt.b   = b_true;
   assign pin_ovr_nxt.b_n = b_comp;

   // the driver stays off until software sets the direction bit
   assign pin_oe_nxt = pin_ovr_nxt & port_dir_in;

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   wire logic [DATA_W-1:0] stat_word;

   assign stat_word = {pin_ovr_out.a, pin_ovr_out.a_n,
                       pin_ovr_out.b, pin_ovr_out.b_n,
                       2'b00, wave_b_r, wave_a_r};
   // force bit masked out of the stored copy, so it reads zero
   assign rdata_nxt = rd_ctrl ? ctrl_a_r
                    : rd_cfg  ? wave_cfg_r
                    : rd_stat ? stat_word
                    : RD_NONE;

   // ---------------------------------------------------------------
   // flip-flops
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_a_r   <= CTRL_A_RST;
         wave_cfg_r <= WAVE_CFG_RST;
         wave_a_r   <= 1'b0;
         wave_b_r   <= 1'b0;
      end else begin
         ctrl_a_r   <= ctrl_a_nxt;
         wave_cfg_r <= wave_cfg_nxt;
         wave_a_r   <= wave_a_nxt;
         wave_b_r   <= wave_b_nxt;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_val_out   <= '0;
         pin_ovr_out   <= '0;
         pin_oe_out    <= '0;
         bus_rdata_out <= RD_NONE;
      end else begin
         pin_val_out   <= pin_val_nxt;
         pin_ovr_out   <= pin_ovr_nxt;
         pin_oe_out    <= pin_oe_nxt;
         bus_rdata_out <= rdata_nxt;
      end
   end

   // match pulses feed interrupt logic outside; force never shows here
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         chan_a_match_out    <= 1'b0;
         chan_b_match_out    <= 1'b0;
         chan_a_waveform_out <= 1'b0;
         chan_b_waveform_out <= 1'b0;
      end else begin
         chan_a_match_out    <= match_a;
         chan_b_match_out    <= match_b;
         chan_a_waveform_out <= wave_a_nxt;
         chan_b_waveform_out <= wave_b_nxt;
      end
   end

endmodule : hstc_cmp_out

// ==== hstc_cmp_out_asserts.sv ====
// concurrent checks on the ports of the compare-output control
module hstc_cmp_out_chk
   import hstc_pkg::*;
(
   input wire logic                            clk_in,
   input wire logic                            arst_n_in,
   input wire hstc_pkg::hstc_bus_req_t         bus_req_in,
   input wire logic [hstc_pkg::DATA_W-1:0]     bus_rdata_out,
   input wire logic [hstc_pkg::CNT_W-1:0]      hs_counter_value_in,
   input wire logic                            timer_tick_in,
   input wire logic [hstc_pkg::CNT_W-1:0]      chan_a_compare_value_in,
   input wire hstc_pkg::hstc_pins_t            port_dir_in,
   input wire hstc_pkg::hstc_pins_t            pin_val_out,
   input wire hstc_pkg::hstc_pins_t            pin_ovr_out,
   input wire hstc_pkg::hstc_pins_t            pin_oe_out,
   input wire logic                            chan_a_waveform_out,
   input wire logic                            chan_a_match_out,
   input wire logic                            chan_b_match_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // shadow of the settings, so mode-dependent checks know the mode
   // ------
   logic [7:0] ctl_r;
   logic [1:0] wg_r;
   logic       cw;
   assign cw = bus_req_in.wr && bus_req_in.addr == OFS_CTRL_A;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctl_r <= 8'h00;
         wg_r  <= 2'h0;
      end else begin
         if (cw) ctl_r <= bus_req_in.wdata;
         if (bus_req_in.wr && bus_req_in.addr == OFS_WAVE_CFG)
            wg_r <= bus_req_in.wdata[1:0];
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_tick_a;
      timer_tick_in && hs_counter_value_in == chan_a_compare_value_in;
   endsequence
   sequence s_force(logic pwm);
      cw && bus_req_in.wdata[CA_FORCE] && bus_req_in.wdata[CA_PWM] == pwm
         && !timer_tick_in;
   endsequence
   property p_rd_idle;
      !bus_req_in.rd |=> bus_rdata_out == RD_NONE;
   endproperty
   property p_force_rd;
      bus_req_in.rd && bus_req_in.addr == OFS_CTRL_A
         |=> !bus_rdata_out[CA_FORCE];
   endproperty
   property p_ovr_a;
      cw |=> pin_ovr_out.a == ($past(bus_req_in.wdata[7:6]) != OM_PORT);
   endproperty
   property p_an_off;
      cw && !bus_req_in.wdata[CA_PWM] |=> !pin_ovr_out.a_n;
   endproperty
   property p_bn_off;
      cw && bus_req_in.wdata[1:0] == 2'h0 |=> !pin_ovr_out.b_n;
   endproperty
   property p_match_a;
      s_tick_a |=> chan_a_match_out;
   endproperty
   property p_no_tick;
      !timer_tick_in |=> !chan_a_match_out && !chan_b_match_out;
   endproperty
   property p_force;
      s_force(1'b0) ##0 (bus_req_in.wdata[7:6] == OM_TOGGLE)
         |=> chan_a_waveform_out != $past(chan_a_waveform_out);
   endproperty
   property p_force_off;
      s_force(1'b1) |=> $stable(chan_a_waveform_out);
   endproperty
   property p_fast_clr;
      (ctl_r[CA_PWM] && wg_r == 2'h0 && ctl_r[7:6] == OM_CLEAR
         && !bus_req_in.wr) ##0 s_tick_a |=> !chan_a_waveform_out;
   endproperty
   property p_six;
      ctl_r[CA_PWM] && wg_r[1] && ctl_r[7:6] != OM_PORT && !bus_req_in.wr
         |=> pin_val_out.b == chan_a_waveform_out
             && pin_val_out.b_n != chan_a_waveform_out;
   endproperty
   property p_oe;
      (port_dir_in == 4'h0) [*3] |-> pin_oe_out == 4'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");
   a_force_rd: assert property (p_force_rd) else $error("force rd");
   a_ovr_a: assert property (p_ovr_a) else $error("ovr a");
   a_an_off: assert property (p_an_off) else $error("a_n ovr");
   a_bn_off: assert property (p_bn_off) else $error("b_n ovr");
   a_match_a: assert property (p_match_a) else $error("no match");
   a_no_tick: assert property (p_no_tick) else $error("match");
   a_force: assert property (p_force) else $error("force");
   a_force_off: assert property (p_force_off) else $error("pwm force");
   a_fast_clr: assert property (p_fast_clr) else $error("fast clr");
   a_six: assert property (p_six) else $error("six pins");
   a_oe: assert property (p_oe) else $error("oe without dir");
endmodule : hstc_cmp_out_chk

// ==== hstc_port_share.sv ====
// port logic model sharing the compare pins with the timer
module hstc_port_share
   import hstc_pkg::*;
(
   input  wire logic                 clk_in,
   input  wire hstc_pkg::hstc_pins_t dir_in,
   input  wire hstc_pkg::hstc_pins_t pin_oe_in,
   input  wire hstc_pkg::hstc_pins_t pin_val_in,
   output hstc_pkg::hstc_pins_t      port_dir_out,
   output hstc_pkg::hstc_pins_t      pad_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // own level flips every cycle so a stale compare value never passes
   logic [3:0] own_r = 4'h5;
   always @(posedge clk_in) own_r <= ~own_r;
   assign port_dir_out = dir_in;
   assign pad_out = (pin_oe_in & pin_val_in) | (~pin_oe_in & own_r);
endmodule : hstc_port_share

// ==== testbench.sv ====
// self-checking bench for the compare-output control
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import hstc_pkg::*;
   // ------
   // steps: ctrl, wave cfg, event (bit3 down; 1 zero 2 match a 3 match b),
   // expected status
   // ------
   localparam logic [23:0] TBL [30] = '{
      24'h480081, 24'h080001, 24'h880080, 24'hC80081,
      24'h4A00C1, 24'h4202C0, 24'h4201C1, 24'h820280,
      24'h820181, 24'hC20180, 24'hC20281, 24'h821280,
      24'h821A81, 24'hC21A80, 24'hC21281, 24'h4212C0,
      24'h8221F1, 24'h8222F0, 24'hC222F1, 24'h022201,
      24'h8232F0, 24'h823AF1, 24'hC23AF0, 24'h112132,
      24'h112330, 24'h113B32, 24'h113330, 24'h211B22,
      24'h101320, 24'h400281};
   logic              clk_in, arst_n_in = 1'b0, rd_d = 1'b0;
   logic              tick = 1'b0, down = 1'b0, wave_a, wave_b, m_a, m_b;
   logic [CNT_W-1:0]  cnt = '0, cmp_a = '0, cmp_b = '0, c;
   logic [DATA_W-1:0] rdata;
   logic [23:0]       s;
   logic [7:0]        e_exp;
   logic              b_exp;
   logic [7:0]        exp_q [$];
   hstc_bus_req_t     req = '0;
   hstc_pins_t        dir = '0, port_dir, val, ovr, oe, pad;
   int                error_cnt = 0, compares = 0, r;
   hstc_cmp_out hstc_cmp_out_i (
      .clk_in, .arst_n_in, .bus_req_in(req), .bus_rdata_out(rdata),
      .hs_counter_value_in(cnt), .count_down_in(down),
      .timer_tick_in(tick), .chan_a_compare_value_in(cmp_a),
      .chan_b_compare_value_in(cmp_b), .port_dir_in(port_dir),
      .pin_val_out(val), .pin_ovr_out(ovr), .pin_oe_out(oe),
      .chan_a_waveform_out(wave_a), .chan_b_waveform_out(wave_b),
      .chan_a_match_out(m_a), .chan_b_match_out(m_b));
   hstc_port_share hstc_port_share_i (
      .clk_in, .dir_in(dir), .pin_oe_in(oe), .pin_val_in(val),
      .port_dir_out(port_dir), .pad_out(pad));
   task automatic check(input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   // one bus or timer cycle; bus request, tick, counter and down are assigned once per edge
   task automatic drv(input logic w, rd, input logic [3:0] a,
         input logic [7:0] d, e, input logic t = 1'b0,
         input logic [9:0] cv = 10'h000, input logic dn = 1'b0);
      req  <= '{addr: a, wdata: d, wr: w, rd: rd};
      tick <= t;
      cnt  <= t ? cv : 10'($urandom);
      down <= dn;
      if (rd) exp_q.push_back(e);
      @(posedge clk_in);
   endtask : drv
   always @(posedge clk_in) begin
      if (rd_d) check(rdata, exp_q.pop_front());
      rd_d <= req.rd;
   end
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   initial begin
      repeat (2000) @(posedge clk_in);
      error_cnt++;
      stop_test();
   end
   initial begin
      void'($urandom(17));
      repeat (8) @(posedge clk_in);
      r = $urandom_range(511, 1);
      arst_n_in <= 1'b1;
      cmp_a <= 10'(r);
      cmp_b <= 10'(r + 512);
      @(posedge clk_in);
      for (int i = 0; i < 4; i++) begin
         drv(0, 1, (i == 3) ? 4'hF : 4'(i), 8'h00, 8'h00);
      end
      drv(1, 0, OFS_CTRL_A, 8'hFF, 8'h00);
      drv(0, 1, OFS_CTRL_A, 8'h00, 8'hF3);
      drv(1, 0, OFS_WAVE_CFG, 8'hFF, 8'h00);
      drv(0, 1, OFS_WAVE_CFG, 8'h00, 8'h03);
      drv(1, 0, 4'h9, 8'($urandom), 8'h00);
      dir <= 4'hF;
      drv(0, 1, 4'h9, 8'h00, 8'h00);
      foreach (TBL[i]) begin
         s = TBL[i];
         drv(1, 0, OFS_CTRL_A, s[23:16], 8'h00);
         drv(1, 0, OFS_WAVE_CFG, {4'h0, s[15:12]}, 8'h00);
         case (s[9:8])
            2'h1: c = CNT_BOTTOM;
            2'h2: c = cmp_a;
            default: c = cmp_b;
         endcase
         drv(0, 0, 4'h0, 8'h00, 8'h00, s[9:8] != 2'h0, c, s[11]);
         drv(0, 1, OFS_STATUS, 8'h00, s[7:0]);
         // outputs seen here still hold what the event edge launched
         e_exp = {4'h0, s[9:8] == 2'h2, s[9:8] == 2'h3, s[1:0]};
         b_exp = (s[17] && s[13]) ? s[0] : s[1];
         check({4'h0, m_a, m_b, wave_b, wave_a}, e_exp);
         check({val, oe}, {s[0], ~s[0], b_exp, ~b_exp, s[7:4]});
      end
      drv(0, 0, 4'h0, 8'h00, 8'h00);
      @(negedge clk_in);
      check({7'h00, pad.a}, 8'h01);
      repeat (2) @(posedge clk_in);
      check(8'(exp_q.size()), 8'h00);
      stop_test();
   end
endmodule : testbench
bind hstc_cmp_out hstc_cmp_out_chk hstc_cmp_out_chk_i (.clk_in, .arst_n_in,
   .bus_req_in, .bus_rdata_out, .hs_counter_value_in, .timer_tick_in,
   .chan_a_compare_value_in, .port_dir_in, .pin_val_out, .pin_ovr_out,
   .pin_oe_out, .chan_a_waveform_out, .chan_a_match_out, .chan_b_match_out);
